// >>> logic/sdrb_regs.svh
// register offsets, field positions and reset values of the solenoid driver register bank
`ifndef SDRB_REGS_SVH
`define SDRB_REGS_SVH

// ****************************************
// bank addresses
// ****************************************
`define SDRB_ADDR_W 4
`define SDRB_ADDR_STATUS 4'h0
`define SDRB_ADDR_CFG_FIRST 4'h1
`define SDRB_ADDR_CFG_LAST 4'h8
`define SDRB_ADDR_FAULT 4'h9
`define SDRB_ADDR_DPM 4'hA

// ****************************************
// global status/control fields
// ****************************************
`define SDRB_ST_ON_MSB 31
`define SDRB_ST_ON_LSB 24
`define SDRB_ST_MASK_MSB 23
`define SDRB_ST_MASK_LSB 17
`define SDRB_ST_OSC_BIT 16
`define SDRB_ST_PAIR_MSB 15
`define SDRB_ST_PAIR_LSB 8
`define SDRB_ST_FLAG_MSB 7
`define SDRB_ST_FLAG_LSB 1
`define SDRB_ST_ACTIVE_BIT 0
`define SDRB_FLAG_OVT 6
`define SDRB_FLAG_OCP 5
`define SDRB_FLAG_OLF 4
`define SDRB_FLAG_HHF 3
`define SDRB_FLAG_DPM 2
`define SDRB_FLAG_COM 1
`define SDRB_FLAG_UVM 0
`define SDRB_FLAGS_RESET 7'h01

// ****************************************
// channel and plunger configuration fields
// ****************************************
`define SDRB_CFG_GUARD_MSB 7
`define SDRB_CFG_GUARD_LSB 6
`define SDRB_CFG_RESET 32'h0000_0000
`define SDRB_DPM_USED_W 15
`define SDRB_DPM_RESET 15'h0000

`endif

// >>> logic/sdrb_pkg.sv
// types shared by the solenoid driver register bank modules
package sdrb_pkg;
	// one channel configuration word, msb first
	typedef struct packed {
		logic half_scale_select;
		logic [6:0] hold_level;
		logic trigger_source_select;
		logic [6:0] hit_level;
		logic [7:0] hit_time;
		logic drive_mode_select;
		logic output_side_select;
		logic [1:0] chop_freq_field;
		logic slew_select;
		logic open_load_enable;
		logic dip_check_enable;
		logic hit_check_enable;
	} sdrb_chan_cfg_t;

	// plunger detection configuration, low used bits only
	typedef struct packed {
		logic [6:0] dip_start_level;
		logic [3:0] dip_debounce_count;
		logic [3:0] dip_threshold;
	} sdrb_dpm_cfg_t;
endpackage : sdrb_pkg

// >>> logic/sdrb_cfg_if.sv
// write path from the bank to one channel configuration register
`timescale 1ns/10ps
interface sdrb_cfg_if;
	logic wr;
	logic byte8;
	logic [31:0] wdata;
	logic chans_off;
	sdrb_pkg::sdrb_chan_cfg_t cfg;

	modport bank (
		output wr,
		output byte8,
		output wdata,
		output chans_off,
		input cfg
	);

	modport chan (
		input wr,
		input byte8,
		input wdata,
		input chans_off,
		output cfg
	);
endinterface : sdrb_cfg_if

// >>> logic/sdrb_chan_cfg.sv
// one channel configuration register with guarded mode bits
`timescale 1ns/10ps
`include "sdrb_regs.svh"
module sdrb_chan_cfg (
	input wire logic clk,
	input wire logic resetn,
	sdrb_cfg_if.chan port
);
	import sdrb_pkg::*;

	logic [31:0] cfg_r;
	logic [31:0] cfg_nxt;

	// ****************************************
	// next value
	// ****************************************
	// short writes reach only the hold byte, so the
	// mode bits need no guard on that path
	always_comb begin
		cfg_nxt = cfg_r;
		if (port.wr) begin
			if (port.byte8) begin
				cfg_nxt[31:24] = port.wdata[7:0];
			end else begin
				cfg_nxt = port.wdata;
				if (!port.chans_off) begin
					// mode and side stay put while any channel on bit is set
					cfg_nxt[`SDRB_CFG_GUARD_MSB:`SDRB_CFG_GUARD_LSB] =
						cfg_r[`SDRB_CFG_GUARD_MSB:`SDRB_CFG_GUARD_LSB];
				end
			end
		end
	end

	// ****************************************
	// storage
	// ****************************************
	// all fields default to zero: full scale, serial trigger, current mode, low side
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_r <= `SDRB_CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign port.cfg = sdrb_chan_cfg_t'(cfg_r);
endmodule : sdrb_chan_cfg

// >>> logic/sdrb_bank.sv
// register bank of the octal solenoid driver
`timescale 1ns/10ps
`include "sdrb_regs.svh"
module sdrb_bank #(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic resetn,
	// register access port, one request per cycle
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_byte8,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// fault events from the drive and diagnostic logic
	input wire logic [7:0] overcurrent_evt,
	input wire logic [7:0] hit_not_reached_evt,
	input wire logic [7:0] open_load_evt,
	input wire logic [7:0] plunger_move_evt,
	input wire logic overtemp_evt,
	input wire logic comm_error_evt,
	input wire logic undervoltage_evt,
	// configuration seen by the drive logic
	output logic [7:0] channel_on_bits,
	output logic [7:0] channel_drive,
	output logic device_active,
	output logic outputs_hiz,
	output logic master_osc_select,
	output logic [7:0] pair_config_field,
	output sdrb_pkg::sdrb_chan_cfg_t [7:0] chan_cfg,
	output sdrb_pkg::sdrb_dpm_cfg_t plunger_detect_config,
	output logic fault_n
);
	import sdrb_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] on_r;
	logic [6:0] mask_r;
	logic osc_r;
	logic [7:0] pair_r;
	logic active_r;
	logic ovt_r;
	logic com_r;
	logic uvm_r;
	logic [7:0] ocp_r;
	logic [7:0] hhf_r;
	logic [7:0] olf_r;
	logic [7:0] pmv_r;
	logic [14:0] dpm_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic [7:0] drive_r;
	logic hiz_r;
	logic fault_n_r;
	logic [6:0] flags;
	logic [31:0] status_word;
	logic [31:0] fault_word;
	logic [31:0] rdata_nxt;
	logic [7:0] cfg_sel;
	logic st_wr;
	logic st_rd;
	logic flt_rd;
	logic dpm_wr;
	logic [31:0] cfg_words [CHANNELS];

	sdrb_cfg_if cfg_bus [CHANNELS] ();

	// ****************************************
	// address decode
	// ****************************************
	// a write and a read in one cycle: the write goes through and
	// the read still answers, with the value from before the write
	assign st_wr = reg_wr && (reg_addr == `SDRB_ADDR_STATUS);
	assign st_rd = reg_rd && (reg_addr == `SDRB_ADDR_STATUS);
	assign flt_rd = reg_rd && (reg_addr == `SDRB_ADDR_FAULT);
	assign dpm_wr = reg_wr && !reg_byte8 && (reg_addr == `SDRB_ADDR_DPM);

	// one-hot select of the channel configuration registers
	always_comb begin
		cfg_sel = 8'h00;
		for (int i = 0; i < CHANNELS; i++) begin
			if (reg_addr == 4'(int'(`SDRB_ADDR_CFG_FIRST) + i)) begin
				cfg_sel[i] = 1'b1;
			end
		end
	end

	// ****************************************
	// channel configuration registers
	// ****************************************
	// every channel gets its own copy of the same register module
	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
			assign cfg_bus[g].wr = reg_wr && cfg_sel[g];
			assign cfg_bus[g].byte8 = reg_byte8;
			assign cfg_bus[g].wdata = reg_wdata;
			assign cfg_bus[g].chans_off = (on_r == 8'h00);
			assign chan_cfg[g] = cfg_bus[g].cfg;
			assign cfg_words[g] = 32'(cfg_bus[g].cfg);

			sdrb_chan_cfg u_cfg (
				.clk(clk),
				.resetn(resetn),
				.port(cfg_bus[g].chan)
			);
		end
	endgenerate

	// ****************************************
	// control part of the status register
	// ****************************************
	// on bits: a short write carries them in its only byte,
	// a full write in the top byte
	always_ff @(posedge clk) begin
		if (!resetn) begin
			on_r <= 8'h00;
		end else if (st_wr && reg_byte8) begin
			on_r <= reg_wdata[7:0];
		end else if (st_wr) begin
			on_r <= reg_wdata[`SDRB_ST_ON_MSB:`SDRB_ST_ON_LSB];
		end
	end

	// fault masks move only on a full write; a short write keeps them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mask_r <= 7'h00;
		end else if (st_wr && !reg_byte8) begin
			mask_r <= reg_wdata[`SDRB_ST_MASK_MSB:`SDRB_ST_MASK_LSB];
		end
	end

	// master oscillator select, full write only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			osc_r <= 1'b0;
		end else if (st_wr && !reg_byte8) begin
			osc_r <= reg_wdata[`SDRB_ST_OSC_BIT];
		end
	end

	// pairing of neighbouring channels, full write only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pair_r <= 8'h00;
		end else if (st_wr && !reg_byte8) begin
			pair_r <= reg_wdata[`SDRB_ST_PAIR_MSB:`SDRB_ST_PAIR_LSB];
		end
	end

	// global enable; low after reset so the outputs start released
	always_ff @(posedge clk) begin
		if (!resetn) begin
			active_r <= 1'b0;
		end else if (st_wr && !reg_byte8) begin
			active_r <= reg_wdata[`SDRB_ST_ACTIVE_BIT];
		end
	end

	// ****************************************
	// summary flags cleared by a status read
	// ****************************************
	// set wins over the read-clear, so an event in the read cycle
	// stays visible for the next read; host writes never reach here
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ovt_r <= 1'b0;
		end else begin
			ovt_r <= overtemp_evt || (ovt_r && !st_rd);
		end
	end

	// communication error, same clearing as overtemperature
	always_ff @(posedge clk) begin
		if (!resetn) begin
			com_r <= 1'b0;
		end else begin
			com_r <= comm_error_evt || (com_r && !st_rd);
		end
	end

	// undervoltage starts set, so the host must read status once first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			uvm_r <= 1'b1;
		end else begin
			uvm_r <= undervoltage_evt || (uvm_r && !st_rd);
		end
	end

	// ****************************************
	// per-channel fault flags cleared by a fault read
	// ****************************************
	// read only: no write path exists into these bits
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ocp_r <= 8'h00;
			hhf_r <= 8'h00;
			olf_r <= 8'h00;
			pmv_r <= 8'h00;
		end else begin
			ocp_r <= overcurrent_evt | (ocp_r & {8{!flt_rd}});
			hhf_r <= hit_not_reached_evt | (hhf_r & {8{!flt_rd}});
			olf_r <= open_load_evt | (olf_r & {8{!flt_rd}});
			pmv_r <= plunger_move_evt | (pmv_r & {8{!flt_rd}});
		end
	end

	// ****************************************
	// plunger detection configuration
	// ****************************************
	// only the low fifteen bits are stored, the rest read as zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dpm_r <= `SDRB_DPM_RESET;
		end else if (dpm_wr) begin
			dpm_r <= reg_wdata[`SDRB_DPM_USED_W-1:0];
		end
	end

	assign plunger_detect_config = sdrb_dpm_cfg_t'(dpm_r);

	// ****************************************
	// assembled read words
	// ****************************************
	// channel summaries follow the per-channel bits, so they drop
	// together with them after a fault read
	always_comb begin
		flags = 7'h00;
		flags[`SDRB_FLAG_OVT] = ovt_r;
		flags[`SDRB_FLAG_OCP] = |ocp_r;
		flags[`SDRB_FLAG_OLF] = |olf_r;
		flags[`SDRB_FLAG_HHF] = |hhf_r;
		flags[`SDRB_FLAG_DPM] = |pmv_r;
		flags[`SDRB_FLAG_COM] = com_r;
		flags[`SDRB_FLAG_UVM] = uvm_r;
	end

	assign status_word = {on_r, mask_r, osc_r, pair_r, flags, active_r};
	assign fault_word = {ocp_r, hhf_r, olf_r, pmv_r};

	// read multiplexer; short reads return the top byte in the low bits
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_addr == `SDRB_ADDR_STATUS) begin
			rdata_nxt = status_word;
		end else if (reg_addr == `SDRB_ADDR_FAULT) begin
			rdata_nxt = fault_word;
		end else if (reg_addr == `SDRB_ADDR_DPM) begin
			rdata_nxt = {17'h0_0000, dpm_r};
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (cfg_sel[i]) begin
					rdata_nxt = cfg_words[i];
				end
			end
		end
		if (reg_byte8) begin
			rdata_nxt = {24'h00_0000, rdata_nxt[31:24]};
		end
	end

	// ****************************************
	// read answer
	// ****************************************
	// answer one cycle after the request; unmapped banks read zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ****************************************
	// outputs toward the drive stage
	// ****************************************
	// registered so the pins follow the bits one cycle later, glitch free
	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive_r <= 8'h00;
		end else begin
			drive_r <= on_r & {8{active_r}};
		end
	end

	// release of the outputs; high from reset until the enable is set
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hiz_r <= 1'b1;
		end else begin
			hiz_r <= !active_r;
		end
	end

	// ****************************************
	// fault pin
	// ****************************************
	// mask bits and flags share one bit order, top bit first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			fault_n_r <= 1'b1;
		end else begin
			fault_n_r <= !(|(flags & ~mask_r));
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign channel_on_bits = on_r;
	assign channel_drive = drive_r;
	assign device_active = active_r;
	assign outputs_hiz = hiz_r;
	assign master_osc_select = osc_r;
	assign pair_config_field = pair_r;
	assign fault_n = fault_n_r;
endmodule : sdrb_bank

// >>> test/sdrb_bank_monitor.sv
// port checker for the solenoid driver register bank
`timescale 1ns/10ps
module sdrb_bank_monitor #(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_byte8,
	input wire logic [31:0] reg_wdata,
	input wire logic [7:0] channel_on_bits,
	input wire logic [7:0] channel_drive,
	input wire logic device_active,
	input wire logic outputs_hiz,
	input wire logic master_osc_select,
	input wire logic [7:0] pair_config_field,
	input sdrb_pkg::sdrb_chan_cfg_t [7:0] chan_cfg,
	input sdrb_pkg::sdrb_dpm_cfg_t plunger_detect_config
);
	import sdrb_pkg::*;
	logic [7:0] dm, sd;
	// ****************************************
	// guarded mode bits gathered across channels
	// ****************************************
	always_comb begin
		dm = 8'h00;
		sd = 8'h00;
		for (int k = 0; k < CHANNELS; k++) begin
			dm[k] = chan_cfg[k].drive_mode_select;
			sd[k] = chan_cfg[k].output_side_select;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_on_byte;
		reg_wr && reg_byte8 && reg_addr == 4'h0 |=> channel_on_bits == $past(reg_wdata[7:0]);
	endproperty
	a_on_byte: assert property (p_on_byte) else $error("on byte write lost");
	property p_drive;
		1'b1 |=> channel_drive == ($past(channel_on_bits) & {8{$past(device_active)}});
	endproperty
	a_drive: assert property (p_drive) else $error("channel drive wrong");
	property p_status;
		reg_wr && !reg_byte8 && reg_addr == 4'h0 |=>
			{master_osc_select, pair_config_field, device_active} ==
			{$past(reg_wdata[16]), $past(reg_wdata[15:8]), $past(reg_wdata[0])};
	endproperty
	a_status: assert property (p_status) else $error("status write lost");
	property p_hiz;
		!device_active |=> outputs_hiz;
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs not released");
	property p_cfg_full;
		reg_wr && !reg_byte8 && reg_addr inside {[4'h1:4'h8]} |=>
			{chan_cfg[$past(reg_addr) - 4'h1][31:8], chan_cfg[$past(reg_addr) - 4'h1][5:0]}
			== {$past(reg_wdata[31:8]), $past(reg_wdata[5:0])};
	endproperty
	a_cfg_full: assert property (p_cfg_full) else $error("config write lost");
	property p_cfg_top;
		reg_wr && reg_byte8 && reg_addr inside {[4'h1:4'h8]} |=>
			chan_cfg[$past(reg_addr) - 4'h1][31:24] == $past(reg_wdata[7:0]);
	endproperty
	a_cfg_top: assert property (p_cfg_top) else $error("config top byte lost");
	property p_mode_guard;
		reg_wr && (|channel_on_bits) |=> $stable(dm);
	endproperty
	a_mode_guard: assert property (p_mode_guard) else $error("mode changed while on");
	property p_side_guard;
		reg_wr && (|channel_on_bits) |=> $stable(sd);
	endproperty
	a_side_guard: assert property (p_side_guard) else $error("side changed while on");
	property p_plunger;
		reg_wr && !reg_byte8 && reg_addr == 4'hA |=> plunger_detect_config == $past(reg_wdata[14:0]);
	endproperty
	a_plunger: assert property (p_plunger) else $error("plunger write lost");
endmodule : sdrb_bank_monitor

bind sdrb_bank sdrb_bank_monitor #(.CHANNELS(CHANNELS)) sdrb_bank_monitor_inst (.clk, .resetn,
	.reg_addr, .reg_wr, .reg_byte8, .reg_wdata, .channel_on_bits, .channel_drive, .device_active,
	.outputs_hiz, .master_osc_select, .pair_config_field, .chan_cfg, .plunger_detect_config);

// >>> test/sdrb_host.sv
// host controller model driving the register port
`timescale 1ns/10ps
module sdrb_host (
	input wire logic clk,
	output logic [3:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic reg_byte8,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle port after power-up
	initial begin
		reg_addr = 4'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_byte8 = 1'b0;
		reg_wdata = 32'h0;
	end
	// one access; strobes last a single cycle, answer taken once settled
	task acc(input logic w, r, b, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic v);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_byte8 <= b;
		reg_addr <= a;
		reg_wdata <= (a == 4'hA) ? {17'h0, d[14:0]} : d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_wdata <= ~d; // idle data is not left looking valid
		#1;
		q = reg_rdata;
		v = reg_rvalid;
	endtask : acc
endmodule : sdrb_host

// >>> test/tb_sdrb_bank.sv
// self-checking bench for the solenoid driver register bank
`timescale 1ns/10ps
module tb_sdrb_bank;
	import sdrb_pkg::*;
	logic clk, resetn, reg_wr, reg_rd, reg_byte8, reg_rvalid, device_active, outputs_hiz;
	logic master_osc_select, fault_n, overtemp_evt, comm_error_evt, undervoltage_evt;
	logic overtemp_flag, com, undervoltage_flag, v;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, st, flt, q, x, e;
	logic [7:0] overcurrent_evt, hit_not_reached_evt, open_load_evt, plunger_move_evt;
	logic [7:0] channel_on_bits, channel_drive, pair_config_field;
	sdrb_chan_cfg_t [7:0] chan_cfg;
	sdrb_dpm_cfg_t plunger_detect_config;
	logic [31:0] cfg [8];
	logic [14:0] plunger_move_flag;
	int fail_count, total_checks, seed;
	sdrb_bank #(.CHANNELS(8)) sdrb_bank_inst (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd,
		.reg_byte8, .reg_wdata, .reg_rdata, .reg_rvalid, .overcurrent_evt, .hit_not_reached_evt,
		.open_load_evt, .plunger_move_evt, .overtemp_evt, .comm_error_evt, .undervoltage_evt,
		.channel_on_bits, .channel_drive, .device_active, .outputs_hiz, .master_osc_select,
		.pair_config_field, .chan_cfg, .plunger_detect_config, .fault_n);
	sdrb_host sdrb_host_inst (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_byte8, .reg_wdata,
		.reg_rdata, .reg_rvalid);
	// ****************************************
	// model and comparison helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] t);
		total_checks++;
		if (g !== t) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, t);
		end
	endtask : chk
	// status word as the model sees it; channel summary bits derive from the fault word
	function logic [31:0] stv();
		return {st[31:8], overtemp_flag, |flt[31:24], |flt[15:8], |flt[23:16], |flt[7:0], com, undervoltage_flag, st[0]};
	endfunction : stv
	task pins();
		@(posedge clk);
		#1;
		x = stv();
		chk(channel_on_bits, st[31:24]);
		chk(channel_drive, st[31:24] & {8{st[0]}});
		chk(device_active, st[0]);
		chk(outputs_hiz, !st[0]);
		chk(master_osc_select, st[16]);
		chk(pair_config_field, st[15:8]);
		chk(fault_n, ~|(x[7:1] & ~st[23:17]));
		for (int i = 0; i < 8; i++) begin
			chk(chan_cfg[i], cfg[i]);
		end
		chk(plunger_detect_config, plunger_move_flag);
	endtask : pins
	task op(input logic w, r, b, input logic [3:0] a, input logic [31:0] d);
		logic [31:0] m;
		m = (a == 4'h0) ? stv() : (a == 4'h9) ? flt : (a == 4'hA) ? {17'h0, plunger_move_flag} : 32'h0;
		if (a >= 4'h1 && a <= 4'h8) m = cfg[a - 1];
		if (b) m = {24'h0, m[31:24]};
		sdrb_host_inst.acc(w, r, b, a, d, q, v);
		chk(v, r);
		if (r) chk(q, m);
		if (r && a == 4'h0) {overtemp_flag, com, undervoltage_flag} = 3'h0;
		if (r && a == 4'h9) flt = 32'h0;
		if (w && a == 4'h0) st = b ? {d[7:0], st[23:0]} : d;
		if (w && a == 4'hA && !b) plunger_move_flag = d[14:0];
		if (w && a >= 4'h1 && a <= 4'h8) begin
			if (b) cfg[a - 1][31:24] = d[7:0];
			else cfg[a - 1] = (|st[31:24]) ? {d[31:8], cfg[a - 1][7:6], d[5:0]} : d;
		end
		pins();
	endtask : op
	// sparse one-cycle fault events, recorded in the model
	task ev();
		e = $random(seed) & $random(seed) & $random(seed);
		x = $random(seed) & $random(seed);
		@(posedge clk);
		{overcurrent_evt, hit_not_reached_evt, open_load_evt, plunger_move_evt} <= e;
		{overtemp_evt, comm_error_evt, undervoltage_evt} <= x[2:0];
		@(posedge clk);
		{overcurrent_evt, hit_not_reached_evt, open_load_evt, plunger_move_evt} <= 32'h0;
		{overtemp_evt, comm_error_evt, undervoltage_evt} <= 3'h0;
		flt = flt | e;
		{overtemp_flag, com, undervoltage_flag} = {overtemp_flag, com, undervoltage_flag} | x[2:0];
	endtask : ev
	task rst(input int n);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (n) @(posedge clk);
		resetn <= 1'b1;
		{st, flt, plunger_move_flag, overtemp_flag, com, undervoltage_flag} = {81'h0, 1'b1};
		foreach (cfg[i]) cfg[i] = 32'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(fault_n, 1'b0);
		op(1'b0, 1'b1, 1'b0, 4'h0, 32'h0);
	endtask : rst
	task results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		seed = 32'h27b1;
		resetn = 1'b0;
		{overcurrent_evt, hit_not_reached_evt, open_load_evt, plunger_move_evt} = 32'h0;
		{overtemp_evt, comm_error_evt, undervoltage_evt} = 3'h0;
		rst(10);
		for (int i = 0; i < 32; i++) op(1'b0, 1'b1, i[4], i[3:0], 32'h0);
		op(1'b1, 1'b0, 1'b0, 4'h0, 32'h0000_0001);
		op(1'b1, 1'b0, 1'b0, 4'h1, 32'hFFFF_FFFF);
		op(1'b1, 1'b0, 1'b1, 4'h0, 32'h0000_0081);
		op(1'b1, 1'b0, 1'b0, 4'h1, 32'h0000_0000);
		op(1'b1, 1'b0, 1'b0, 4'h9, 32'hFFFF_FFFF);
		op(1'b1, 1'b1, 1'b0, 4'hA, 32'hFFFF_FFFF);
		op(1'b1, 1'b0, 1'b1, 4'hA, 32'h0000_00FF);
		// random traffic; reads and writes may share a cycle
		repeat (300) begin
			ev();
			x = $random(seed);
			op(x[0], x[1] | !x[0], x[2], x[7:4], $random(seed));
		end
		rst(3);
		results();
	end
	initial begin
		#100000;
		fail_count++;
		results();
	end
endmodule : tb_sdrb_bank
